// [inc/sysctl_pkg.sv]
// Purpose: Shared constants and types of the system control block
// Assumes: 8-bit special-function-register space
// Notes:   Offsets are register addresses in that space
package sysctl_pkg;

  localparam logic [7:0] ADDR_POWER    = 8'h87;
  localparam logic [7:0] ADDR_CORE_CLOCK_SELECT    = 8'h8F;
  localparam logic [7:0] ADDR_ACCESS   = 8'h9D;
  localparam logic [7:0] ADDR_DIVMODE  = 8'hC4;
  localparam logic [7:0] ADDR_MEMCTL   = 8'hC6;
  localparam logic [7:0] ADDR_KEY_A    = 8'hC7;
  localparam logic [7:0] ADDR_KEY_B    = 8'hC9;
  localparam logic [7:0] ADDR_WDOG     = 8'hD8;

  localparam logic [7:0] KEY_FIRST     = 8'hAA;
  localparam logic [7:0] KEY_SECOND    = 8'h55;
  localparam logic [7:0] KEY_CLOSE     = 8'h00;

  // Power mode control fields
  localparam int POW_IDLE_BIT  = 0;
  localparam int POW_STOP_BIT  = 1;
  localparam int POW_SLEEP_BIT = 2;
  localparam int POW_SMOD_BIT  = 7;

  // Clock divider mode fields
  localparam int DIV_HIGH_BIT  = 7;
  localparam int DIV_LOW_BIT   = 6;
  localparam int DIV_SWB_BIT   = 5;
  localparam logic DIV_LOW_RST = 1'b1;
  localparam logic DIV_SWB_RST = 1'b0;

  // Clock select fields and reset value
  localparam int CK_PREDIV_LSB = 4;
  localparam int CK_SETTLE_LSB = 2;
  localparam int CK_SRC_LSB    = 0;
  localparam logic [7:0] CORE_CLOCK_SELECT_RST = 8'h0C;

  localparam logic [1:0] SRC_FAST_A = 2'h0;
  localparam logic [1:0] SRC_SLOW   = 2'h1;
  localparam logic [1:0] SRC_FAST_B = 2'h2;
  localparam logic [1:0] SRC_EXT    = 2'h3;

  // Window length in system-clock periods and settle delays in slow ticks
  localparam int          WINDOW_CYCLES = 256;
  localparam int          CNT_W         = 9;
  localparam logic [8:0]  SETTLE_0      = 9'h008;
  localparam logic [8:0]  SETTLE_1      = 9'h010;
  localparam logic [8:0]  SETTLE_2      = 9'h040;
  localparam logic [8:0]  SETTLE_3      = 9'h100;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_STOP,
    MODE_SLEEP,
    MODE_SETTLE
  } power_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic       cpu_clk_en;
    logic       periph_clk_en;
    logic       fast_osc_en;
    logic       main_reg_en;
    logic       integ_periph_rst;
  } power_out_s;

  typedef struct packed {
    logic [1:0] core_clock_source;
    logic [3:0] fast_osc_prediv;
    logic [1:0] regulator_settle_sel;
    logic [8:0] fast_div_ratio;
  } clock_out_s;

endpackage

// [logic/sysctl.sv]
// Purpose: Timed-access keys, power modes and clock selection
// Assumes: CPU register requests are synchronous to clk
// Notes:   Guarded registers outside are written only on the grant pulses
//
// Operation
// - Key unlocks after 0xAA then 0x55
// - One guarded write relocks the key
// - Guarded register reads are never blocked
// - Key guards watchdog, memory, access registers
// - No timeout; key address access cancels unlock
// - Key read bit 0 shows unlock
// - Window key opens 256-cycle write window
// - Repeated sequence restarts the window
// - Writing 0x00 closes window at once
// - Window key read bit 0 shows open
// - Keys freeze while CPU clock stopped
// - Sleep and stop bits enter sleep
// - Sleep wake-up waits for regulator settle
// - Stop bit alone gates all clocks
// - Idle stops CPU, resets integrated peripherals
// - Upper divider bit reads zero always
// - Pre-divider code maps to divide ratio
// - Clock select resets 0x0C, window guarded
// - Source select picks fast, slow, external
// - Settle field picks 8/16/64/256 slow ticks
`timescale 1ns/1ns
`default_nettype none

module sysctl #(
  parameter int WINDOW_LEN = sysctl_pkg::WINDOW_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire sysctl_pkg::sfr_req_s   sfr_req,
  output logic [7:0]                  sfr_rdata,
  input  wire logic                   wake_event,
  input  wire logic                   slow_tick,
  output logic                        guarded_wr_en,
  output logic                        window_wr_en,
  output logic                        single_key_unlocked,
  output logic                        window_key_open,
  output sysctl_pkg::power_out_s      power_out,
  output sysctl_pkg::clock_out_s      clock_out
);

  typedef struct packed {
    sysctl_pkg::power_mode_e mode;
    logic                    armed_a;
    logic                    unl_a;
    logic                    armed_b;
    logic [8:0]              win_cnt;
    logic [7:0]              rdata;
    logic                    smod;
    logic                    sleep_b;
    logic                    stop_b;
    logic                    idle_b;
    logic [3:0]              prediv;
    logic [1:0]              settle;
    logic [1:0]              src;
    logic                    div_low;
    logic                    switch_back_bit;
    logic [8:0]              div_ratio;
    logic [8:0]              settle_cnt;
  } ctl_s;

  localparam logic [8:0] WIN_LOAD = 9'(WINDOW_LEN);

  ctl_s st_q;
  ctl_s st_d;

  logic wr_a;
  logic rd_a;
  logic wr_b;
  logic guarded_hit;
  logic running;

  function automatic logic [8:0] div_of(input logic [3:0] code);
    logic [8:0] r;
    r = 9'h100;
    if (code == 4'h0) begin
      r = 9'h001;
    end else if (code <= 4'h8) begin
      r = {4'h0, code, 1'b0};
    end else if (code == 4'h9) begin
      r = 9'h020;
    end else if (code == 4'hA) begin
      r = 9'h040;
    end else if (code == 4'hB) begin
      r = 9'h080;
    end
    return r;
  endfunction

  function automatic logic [8:0] settle_of(input logic [1:0] sel);
    logic [8:0] r;
    case (sel)
      2'h0:    r = sysctl_pkg::SETTLE_0;
      2'h1:    r = sysctl_pkg::SETTLE_1;
      2'h2:    r = sysctl_pkg::SETTLE_2;
      default: r = sysctl_pkg::SETTLE_3;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  assign wr_a = sfr_req.wr && sfr_req.addr == sysctl_pkg::ADDR_KEY_A;
  assign rd_a = sfr_req.rd && sfr_req.addr == sysctl_pkg::ADDR_KEY_A;
  assign wr_b = sfr_req.wr && sfr_req.addr == sysctl_pkg::ADDR_KEY_B;
  assign guarded_hit = sfr_req.wr &&
                       (sfr_req.addr == sysctl_pkg::ADDR_WDOG ||
                        sfr_req.addr == sysctl_pkg::ADDR_MEMCTL ||
                        sfr_req.addr == sysctl_pkg::ADDR_ACCESS);
  assign running = st_q.mode == sysctl_pkg::MODE_RUN;

  // Grants; reads are never gated
  assign guarded_wr_en = guarded_hit && st_q.unl_a;
  assign window_wr_en  = sfr_req.wr && st_q.win_cnt != 9'h000 &&
                         sfr_req.addr != sysctl_pkg::ADDR_KEY_B;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d = st_q;

    // Single-use key
    if (guarded_wr_en) begin
      st_d.unl_a = 1'b0;
    end
    if (rd_a) begin
      st_d.unl_a   = 1'b0;
      st_d.armed_a = 1'b0;
    end
    if (wr_a) begin
      st_d.unl_a   = 1'b0;
      st_d.armed_a = sfr_req.wdata == sysctl_pkg::KEY_FIRST;
      if (st_q.armed_a && sfr_req.wdata == sysctl_pkg::KEY_SECOND) begin
        st_d.unl_a = 1'b1;
      end
    end

    // Window key, frozen while the CPU clock is stopped
    if (running && st_q.win_cnt != 9'h000) begin
      st_d.win_cnt = st_q.win_cnt - 9'h001;
    end
    if (wr_b) begin
      st_d.armed_b = sfr_req.wdata == sysctl_pkg::KEY_FIRST;
      if (st_q.armed_b && sfr_req.wdata == sysctl_pkg::KEY_SECOND) begin
        st_d.win_cnt = WIN_LOAD;
      end else if (sfr_req.wdata == sysctl_pkg::KEY_CLOSE) begin
        st_d.win_cnt = 9'h000;
      end
    end

    // Clock select, writable only inside the window
    if (sfr_req.wr && sfr_req.addr == sysctl_pkg::ADDR_CORE_CLOCK_SELECT &&
        st_q.win_cnt != 9'h000) begin
      st_d.prediv = sfr_req.wdata[sysctl_pkg::CK_PREDIV_LSB +: 4];
      st_d.settle = sfr_req.wdata[sysctl_pkg::CK_SETTLE_LSB +: 2];
      st_d.src    = sfr_req.wdata[sysctl_pkg::CK_SRC_LSB +: 2];
    end
    st_d.div_ratio = div_of(st_d.prediv);

    // Divider mode: the upper bit is not stored
    if (sfr_req.wr && sfr_req.addr == sysctl_pkg::ADDR_DIVMODE) begin
      st_d.div_low = sfr_req.wdata[sysctl_pkg::DIV_LOW_BIT];
      st_d.switch_back_bit     = sfr_req.wdata[sysctl_pkg::DIV_SWB_BIT];
    end

    // Power modes
    case (st_q.mode)
      sysctl_pkg::MODE_RUN: begin
        if (sfr_req.wr && sfr_req.addr == sysctl_pkg::ADDR_POWER) begin
          st_d.smod    = sfr_req.wdata[sysctl_pkg::POW_SMOD_BIT];
          st_d.sleep_b = sfr_req.wdata[sysctl_pkg::POW_SLEEP_BIT];
          st_d.stop_b  = sfr_req.wdata[sysctl_pkg::POW_STOP_BIT];
          st_d.idle_b  = sfr_req.wdata[sysctl_pkg::POW_IDLE_BIT];
          if (st_d.stop_b && st_d.sleep_b) begin
            st_d.mode = sysctl_pkg::MODE_SLEEP;
          end else if (st_d.stop_b) begin
            st_d.mode = sysctl_pkg::MODE_STOP;
          end else if (st_d.idle_b) begin
            st_d.mode = sysctl_pkg::MODE_IDLE;
          end
        end
      end
      sysctl_pkg::MODE_IDLE: begin
        if (wake_event) begin
          st_d.mode   = sysctl_pkg::MODE_RUN;
          st_d.idle_b = 1'b0;
        end
      end
      sysctl_pkg::MODE_STOP: begin
        if (wake_event) begin
          st_d.mode   = sysctl_pkg::MODE_RUN;
          st_d.stop_b = 1'b0;
          st_d.idle_b = 1'b0;
        end
      end
      sysctl_pkg::MODE_SLEEP: begin
        if (wake_event) begin
          st_d.mode       = sysctl_pkg::MODE_SETTLE;
          st_d.settle_cnt = settle_of(st_q.settle);
        end
      end
      sysctl_pkg::MODE_SETTLE: begin
        if (slow_tick) begin
          st_d.settle_cnt = st_q.settle_cnt - 9'h001;
          if (st_q.settle_cnt == 9'h001) begin
            st_d.mode    = sysctl_pkg::MODE_RUN;
            st_d.sleep_b = 1'b0;
            st_d.stop_b  = 1'b0;
            st_d.idle_b  = 1'b0;
          end
        end
      end
      default: begin
        st_d.mode = sysctl_pkg::MODE_RUN;
      end
    endcase

    // Read data
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        sysctl_pkg::ADDR_KEY_A:   st_d.rdata = {7'h00, st_q.unl_a};
        sysctl_pkg::ADDR_KEY_B:   st_d.rdata = {7'h00,
                                   st_q.win_cnt != 9'h000};
        sysctl_pkg::ADDR_POWER:   st_d.rdata = {st_q.smod, 7'h00};
        sysctl_pkg::ADDR_DIVMODE: st_d.rdata = {1'b0, st_q.div_low,
                                   st_q.switch_back_bit, 5'h00};
        sysctl_pkg::ADDR_CORE_CLOCK_SELECT:   st_d.rdata = {st_q.prediv, 2'h0,
                                   st_q.src};
        default:                  st_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.mode       <= sysctl_pkg::MODE_RUN;
      st_q.armed_a    <= 1'b0;
      st_q.unl_a      <= 1'b0;
      st_q.armed_b    <= 1'b0;
      st_q.win_cnt    <= 9'h000;
      st_q.rdata      <= 8'h00;
      st_q.smod       <= 1'b0;
      st_q.sleep_b    <= 1'b0;
      st_q.stop_b     <= 1'b0;
      st_q.idle_b     <= 1'b0;
      st_q.prediv     <= sysctl_pkg::CORE_CLOCK_SELECT_RST[sysctl_pkg::CK_PREDIV_LSB +: 4];
      st_q.settle     <= sysctl_pkg::CORE_CLOCK_SELECT_RST[sysctl_pkg::CK_SETTLE_LSB +: 2];
      st_q.src        <= sysctl_pkg::CORE_CLOCK_SELECT_RST[sysctl_pkg::CK_SRC_LSB +: 2];
      st_q.div_low    <= sysctl_pkg::DIV_LOW_RST;
      st_q.switch_back_bit        <= sysctl_pkg::DIV_SWB_RST;
      st_q.div_ratio  <= 9'h001;
      st_q.settle_cnt <= 9'h000;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sfr_rdata           = st_q.rdata;
  assign single_key_unlocked = st_q.unl_a;
  assign window_key_open     = st_q.win_cnt != 9'h000;

  assign power_out.cpu_clk_en       = running;
  assign power_out.periph_clk_en    = running ||
                                      st_q.mode == sysctl_pkg::MODE_IDLE;
  assign power_out.fast_osc_en      = running ||
                                      st_q.mode == sysctl_pkg::MODE_IDLE;
  assign power_out.main_reg_en      = st_q.mode != sysctl_pkg::MODE_SLEEP &&
                                      st_q.mode != sysctl_pkg::MODE_SETTLE;
  assign power_out.integ_periph_rst = st_q.mode == sysctl_pkg::MODE_IDLE;

  assign clock_out.core_clock_source    = st_q.src;
  assign clock_out.fast_osc_prediv      = st_q.prediv;
  assign clock_out.regulator_settle_sel = st_q.settle;
  assign clock_out.fast_div_ratio       = st_q.div_ratio;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_key_unlock_seq: assert property (
    wr_a && st_q.armed_a && sfr_req.wdata == sysctl_pkg::KEY_SECOND
    |=> single_key_unlocked)
    else $error("key did not unlock after second byte");

  a_key_one_use: assert property (
    guarded_wr_en ##1 !wr_a |-> !single_key_unlocked)
    else $error("key still unlocked after guarded write");

  a_key_locked_drop: assert property (
    guarded_hit && !single_key_unlocked |-> !guarded_wr_en)
    else $error("guarded write granted while locked");

  a_key_access_void: assert property (
    rd_a |=> !single_key_unlocked)
    else $error("key access did not cancel unlock");

  a_key_no_timeout: assert property (
    single_key_unlocked && !rd_a && !wr_a && !guarded_hit
    |=> single_key_unlocked)
    else $error("unlock lost without access");

  a_win_open_len: assert property (
    wr_b && st_q.armed_b && sfr_req.wdata == sysctl_pkg::KEY_SECOND
    ##1 (running && !wr_b) [*8]
    |-> window_key_open && st_q.win_cnt == WIN_LOAD - 9'd7)
    else $error("window length wrong");

  a_win_close_now: assert property (
    wr_b && sfr_req.wdata == sysctl_pkg::KEY_CLOSE |=> !window_key_open)
    else $error("window not closed by zero write");

  a_win_frozen: assert property (
    !running |=> st_q.win_cnt == $past(st_q.win_cnt) || $past(wr_b))
    else $error("window counted while clock stopped");

  a_div_high_zero: assert property (
    sfr_req.rd && sfr_req.addr == sysctl_pkg::ADDR_DIVMODE
    |=> sfr_rdata[sysctl_pkg::DIV_HIGH_BIT] == 1'b0)
    else $error("upper divider bit read as one");

  a_core_clock_select_guard: assert property (
    sfr_req.wr && sfr_req.addr == sysctl_pkg::ADDR_CORE_CLOCK_SELECT && !window_key_open
    |=> $stable(clock_out.core_clock_source))
    else $error("clock select written with window shut");

  a_sleep_power: assert property (
    st_q.mode == sysctl_pkg::MODE_SLEEP
    |-> !power_out.main_reg_en && !power_out.cpu_clk_en &&
        !power_out.periph_clk_en)
    else $error("sleep left clocks or regulator on");

  a_settle_ends: assert property (
    st_q.mode == sysctl_pkg::MODE_SETTLE && slow_tick &&
    st_q.settle_cnt == 9'h001 |=> running && !st_q.sleep_b && !st_q.stop_b)
    else $error("settle end did not resume run");

  c_guarded_write: cover property (
    single_key_unlocked ##1 guarded_wr_en);
  c_window_expire: cover property (
    st_q.win_cnt == 9'h001 && running ##1 !window_key_open);
  c_sleep_wake: cover property (
    st_q.mode == sysctl_pkg::MODE_SETTLE ##[1:300] running);
  c_idle_wake: cover property (
    st_q.mode == sysctl_pkg::MODE_IDLE && wake_event);

endmodule

`default_nettype wire

// [verification/cpu_model.sv]
// Purpose: CPU side model issuing register reads and writes
// Assumes: One request per cycle, launched just after a rising edge
// Notes:   Each task returns mid-cycle so grants can be sampled settled
`timescale 1ns/1ns
`default_nettype none

module cpu_model (
  input  wire logic                 clk,
  output var  sysctl_pkg::sfr_req_s req
);
  initial req = '0;

  task automatic xfer(input logic w, input logic r, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    req <= {w, r, a, d};
    #50;
  endtask

  task automatic idle();
    @(posedge clk);
    req <= '0;
    #50;
  endtask

  // Both key bytes on consecutive writes
  task automatic key_seq(input logic [7:0] a);
    xfer(1'b1, 1'b0, a, sysctl_pkg::KEY_FIRST);
    xfer(1'b1, 1'b0, a, sysctl_pkg::KEY_SECOND);
  endtask

  // Drop both keys before a low-power mode
  task automatic close_keys();
    xfer(1'b0, 1'b1, sysctl_pkg::ADDR_KEY_A, 8'h00);
    xfer(1'b1, 1'b0, sysctl_pkg::ADDR_KEY_B, sysctl_pkg::KEY_CLOSE);
  endtask
endmodule

`default_nettype wire

// [verification/timed_access_power_clock_ctrl_test.sv]
// Purpose: Self-checking bench of keys, power modes and clock select
// Assumes: Window shortened to 16 cycles through WINDOW_LEN
// Notes:   Outputs are sampled mid-cycle, inputs change on rising edges
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module timed_access_power_clock_ctrl_test;
  localparam int         WL = 16;
  localparam logic [7:0] KA = sysctl_pkg::ADDR_KEY_A;
  localparam logic [7:0] KB = sysctl_pkg::ADDR_KEY_B;
  localparam logic [7:0] CK = sysctl_pkg::ADDR_CORE_CLOCK_SELECT;
  localparam logic [7:0] PW = sysctl_pkg::ADDR_POWER;

  logic                   clk;
  logic                   rst_n;
  logic                   wake_event;
  logic                   slow_tick;
  sysctl_pkg::sfr_req_s   sfr_req;
  logic [7:0]             sfr_rdata;
  logic                   guarded_wr_en;
  logic                   window_wr_en;
  logic                   single_key_unlocked;
  logic                   window_key_open;
  sysctl_pkg::power_out_s power_out;
  sysctl_pkg::clock_out_s clock_out;
  int                     miscompares;
  int                     n_compared;
  int                     cycles;
  int                     n;
  logic [7:0]             v;

  sysctl #(.WINDOW_LEN(WL)) dut_u (
    .clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .wake_event(wake_event), .slow_tick(slow_tick),
    .guarded_wr_en(guarded_wr_en), .window_wr_en(window_wr_en),
    .single_key_unlocked(single_key_unlocked),
    .window_key_open(window_key_open), .power_out(power_out),
    .clock_out(clock_out)
  );

  cpu_model cpu_u (.clk(clk), .req(sfr_req));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [8:0] ratio(input int c);
    if (c == 0) return 9'h001;
    if (c <= 8) return 9'(2 * c);
    if (c <= 11) return 9'h020 << (c - 9);
    return 9'h100;
  endfunction

  task automatic rd(input logic [7:0] a);
    cpu_u.xfer(1'b0, 1'b1, a, 8'h00);
    cpu_u.idle();
    v = sfr_rdata;
  endtask

  task automatic open_win();
    cpu_u.key_seq(KB);
    cpu_u.idle();
  endtask

  task automatic count_open();
    n = 0;
    while (window_key_open === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
      #50;
    end
  endtask

  task automatic wake();
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    #50;
  endtask

  // Sleep entry and settle wake-up with the given clock select value
  task automatic sleep_cycle(input logic [7:0] ck, input int ticks);
    open_win();
    cpu_u.xfer(1'b1, 1'b0, CK, ck);
    cpu_u.close_keys();
    cpu_u.xfer(1'b1, 1'b0, PW, 8'h06);
    cpu_u.idle();
    `CHK(power_out, 5'h00)
    wake();
    `CHK(power_out, 5'h00)
    n = 0;
    while (power_out.cpu_clk_en !== 1'b1 && n < 300) begin
      @(posedge clk);
      slow_tick <= 1'b1;
      @(posedge clk);
      slow_tick <= 1'b0;
      n++;
      @(posedge clk);
      #50;
    end
    `CHK(n, ticks)
    `CHK(clock_out.core_clock_source, 2'h1)
    rd(PW);
    `CHK(v, 8'h00)
  endtask

  task automatic t_reset();
    `CHK(single_key_unlocked, 1'b0)
    `CHK(clock_out.regulator_settle_sel, 2'h3)
    `CHK(clock_out.fast_div_ratio, 9'h001)
    rd(PW);
    `CHK(v, 8'h00)
    rd(CK);
    `CHK(v, 8'h00)
    rd(sysctl_pkg::ADDR_DIVMODE);
    `CHK(v & 8'hE0, 8'h40)
    cpu_u.xfer(1'b1, 1'b0, sysctl_pkg::ADDR_DIVMODE, 8'hFF);
    rd(sysctl_pkg::ADDR_DIVMODE);
    `CHK(v[7], 1'b0)
  endtask

  task automatic t_single_key();
    logic [7:0] g [3];
    g = '{sysctl_pkg::ADDR_WDOG, sysctl_pkg::ADDR_MEMCTL,
          sysctl_pkg::ADDR_ACCESS};
    for (int i = 0; i < 3; i++) begin
      cpu_u.key_seq(KA);
      cpu_u.xfer(1'b0, 1'b1, g[i], 8'h00);
      `CHK(guarded_wr_en, 1'b0)
      cpu_u.xfer(1'b1, 1'b0, g[i], 8'h5A);
      `CHK(guarded_wr_en, 1'b1)
      cpu_u.xfer(1'b1, 1'b0, g[i], 8'h5B);
      `CHK(guarded_wr_en, 1'b0)
    end
    cpu_u.xfer(1'b1, 1'b0, KA, sysctl_pkg::KEY_FIRST);
    cpu_u.xfer(1'b1, 1'b0, KA, 8'h12);
    cpu_u.xfer(1'b1, 1'b0, KA, sysctl_pkg::KEY_SECOND);
    cpu_u.idle();
    `CHK(single_key_unlocked, 1'b0)
    cpu_u.key_seq(KA);
    cpu_u.idle();
    repeat (300) @(posedge clk);
    #50;
    `CHK(single_key_unlocked, 1'b1)
    rd(KA);
    `CHK(v[0], 1'b1)
    `CHK(single_key_unlocked, 1'b0)
    rd(KA);
    `CHK(v[0], 1'b0)
  endtask

  task automatic t_window();
    cpu_u.xfer(1'b1, 1'b0, CK, 8'hA7);
    rd(CK);
    `CHK(v, 8'h00)
    open_win();
    count_open();
    `CHK(n, WL)
    open_win();
    repeat (8) @(posedge clk);
    open_win();
    count_open();
    `CHK(n, WL)
    open_win();
    cpu_u.xfer(1'b1, 1'b0, CK, 8'hA7);
    `CHK(window_wr_en, 1'b1)
    rd(KB);
    `CHK(v[0], 1'b1)
    rd(CK);
    `CHK(v, 8'hA3)
    `CHK(clock_out.core_clock_source, 2'h3)
    `CHK(clock_out.regulator_settle_sel, 2'h1)
    `CHK(clock_out.fast_div_ratio, 9'h040)
    `CHK(clock_out.fast_osc_prediv, 4'hA)
    cpu_u.xfer(1'b1, 1'b0, KB, sysctl_pkg::KEY_CLOSE);
    cpu_u.idle();
    `CHK(window_key_open, 1'b0)
    rd(KB);
    `CHK(v[0], 1'b0)
  endtask

  task automatic t_prediv();
    for (int c = 0; c < 16; c++) begin
      open_win();
      cpu_u.xfer(1'b1, 1'b0, CK, {4'(c), 4'h1});
      cpu_u.idle();
      `CHK(clock_out.fast_div_ratio, ratio(c))
      `CHK(clock_out.core_clock_source, 2'h1)
    end
    cpu_u.close_keys();
  endtask

  task automatic t_power();
    cpu_u.xfer(1'b1, 1'b0, PW, 8'h02);
    cpu_u.idle();
    repeat (5) @(posedge clk);
    #50;
    `CHK(power_out, 5'h02)
    wake();
    `CHK(power_out, 5'h1E)
    open_win();
    cpu_u.xfer(1'b1, 1'b0, PW, 8'h01);
    cpu_u.idle();
    `CHK(power_out, 5'h0F)
    repeat (40) @(posedge clk);
    #50;
    `CHK(window_key_open, 1'b1)
    wake();
    `CHK(power_out, 5'h1E)
    count_open();
    `CHK(n, WL - 2)
    sleep_cycle(8'h01, 8);
    sleep_cycle(8'h05, 16);
  endtask

  initial begin
    rst_n = 1'b0;
    wake_event = 1'b0;
    slow_tick = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #50;
    t_reset();
    t_single_key();
    t_window();
    t_prediv();
    t_power();
    print_verdict();
  end
endmodule

`default_nettype wire
